// *** rshm_ee_model.sv ***
`timescale 1ns/10ps
module rshm_ee_model (
    input  wire logic   i_cs_n,
    input  wire logic   i_sclk,
    input  wire logic   i_mosi,
    output logic        o_miso,
    output logic [23:0] o_hdr
);
    // ****************************************
    // eeprom: byte at a is a xor 5A
    // ****************************************
    int         bit_cnt = 0;
    logic [7:0] cur;
    initial o_miso = 1'b0;
    initial o_hdr = '0;
    always @(posedge i_sclk) begin
        if (!i_cs_n && bit_cnt < 24) begin
            o_hdr <= {o_hdr[22:0], i_mosi};
        end
        if (!i_cs_n) begin
            bit_cnt <= bit_cnt + 1;
        end
    end
    // data moves on falling clock, device samples on rising
    always @(negedge i_sclk) begin
        if (!i_cs_n && bit_cnt >= 24) begin
            cur = (o_hdr[7:0] + 8'((bit_cnt - 24) / 8)) ^ 8'h5A;
            o_miso <= cur[7 - ((bit_cnt - 24) % 8)];
        end
    end
    // released line flips so a stale bit never passes
    always @(posedge i_cs_n) begin
        o_miso  <= ~o_miso;
        bit_cnt <= 0;
    end
endmodule

// *** rshm_pin_mux.sv ***
`timescale 1ns/10ps
module rshm_pin_mux
    import rshm_pkg::*;
#(
    parameter int   SCLK_DIV   = SCLK_DIV_DEF,
    parameter int   CFG_BYTES  = CFG_BYTES_DEF,
    parameter logic REV_A      = 1'b0
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_link_clk,
    input  wire logic       i_autocfg_sel0_or_io0,
    output logic            o_autocfg_sel0_or_io0,
    output logic            o_autocfg_sel0_or_io0_oe,
    input  wire logic       i_autocfg_sel1_or_io1,
    output logic            o_autocfg_sel1_or_io1,
    output logic            o_autocfg_sel1_or_io1_oe,
    input  wire logic       i_factory_test_or_io2,
    output logic            o_factory_test_or_io2,
    output logic            o_factory_test_or_io2_oe,
    input  wire logic       i_ifmode0_or_chip_select_n,
    output logic            o_ifmode0_or_chip_select_n,
    output logic            o_ifmode0_or_chip_select_n_oe,
    input  wire logic       i_ifmode1_or_serial_out,
    output logic            o_ifmode1_or_serial_out,
    output logic            o_ifmode1_or_serial_out_oe,
    input  wire logic       i_host_clk_pin,
    output logic            o_host_clk_pin,
    output logic            o_host_clk_pin_oe,
    input  wire logic       i_host_data_pin,
    output logic            o_host_data_pin,
    output logic            o_host_data_pin_oe,
    input  wire logic [3:0] i_general_io_config_1,
    input  wire logic [1:0] i_general_io_config_2,
    output logic [2:0]      o_general_io_state,
    output rshm_strap_t     o_strap_capture_status,
    output logic            o_strap_valid,
    output logic            o_factory_test_mode,
    input  wire logic       i_i2c_sda_pull_low,
    input  wire logic       i_i2c_access_busy,
    output logic            o_i2c_scl_level,
    output logic            o_i2c_sda_level,
    input  wire logic [7:0] i_spi_tx_byte,
    output logic [7:0]      o_spi_rx_byte,
    output logic            o_spi_rx_valid,
    output logic [7:0]      o_ee_byte,
    output logic            o_ee_byte_valid,
    output logic            o_autocfg_busy,
    output logic            o_autocfg_done
);
    // ************************************************************
    // decode helper
    // ************************************************************
    function automatic logic mode_is(input rshm_strap_t s, input logic [1:0] m);
        mode_is = (s.host_mode == m);
    endfunction

    localparam logic [EE_CNT_W-1:0] EE_TOTAL = EE_CNT_W'(EE_HDR_BITS + 8 * CFG_BYTES);
    localparam logic [EE_CNT_W-1:0] EE_HDR   = EE_CNT_W'(EE_HDR_BITS);
    localparam logic [7:0]          DIV_LAST = 8'(SCLK_DIV - 1);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_s;
    logic                link_miso;
    logic [7:0]          link_rx_byte;
    logic                link_rx_toggle;
    logic                rx_toggle_s;

    assign pin_raw = {i_host_data_pin, i_host_clk_pin, i_ifmode1_or_serial_out,
                      i_ifmode0_or_chip_select_n, i_factory_test_or_io2,
                      i_autocfg_sel1_or_io1, i_autocfg_sel0_or_io0};

    rshm_sync #(.W(NUM_PINS)) u_pin_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_async (pin_raw),
        .o_sync  (pin_s)
    );

    rshm_sync #(.W(1)) u_tog_sync (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_ce    (i_ce),
        .i_async (link_rx_toggle),
        .o_sync  (rx_toggle_s)
    );

    // ************************************************************
    // strap capture
    // ************************************************************
    logic [1:0]  cap_cnt_reg;
    rshm_strap_t strap_reg;
    logic        is_i2c;
    logic        is_slave;
    logic        is_master;
    logic        slave_en_reg;

    assign strap_reg = o_strap_capture_status;
    assign is_i2c    = o_strap_valid & mode_is(strap_reg, MODE_I2C);
    assign is_slave  = o_strap_valid & mode_is(strap_reg, MODE_SPI_SLAVE);
    assign is_master = o_strap_valid & mode_is(strap_reg, MODE_SPI_MASTER);

    // levels seen only once the synchronisers hold post-release values
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cap_cnt_reg            <= 2'h0;
            o_strap_valid          <= 1'b0;
            o_strap_capture_status <= '0;
            o_factory_test_mode    <= 1'b0;
        end else if (i_ce && !o_strap_valid) begin
            if (cap_cnt_reg == CAPTURE_WAIT) begin
                o_strap_valid <= 1'b1;
                o_strap_capture_status.autocfg_select <= pin_s[PIN_IO1:PIN_IO0];
                o_strap_capture_status.factory_test   <= pin_s[PIN_IO2];
                o_strap_capture_status.host_mode <= {pin_s[PIN_MISO], pin_s[PIN_CS]};
                o_factory_test_mode <= pin_s[PIN_IO2];
            end else begin
                cap_cnt_reg <= cap_cnt_reg + 2'h1;
            end
        end
    end

    // ************************************************************
    // general io
    // ************************************************************
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_autocfg_sel0_or_io0    <= 1'b0;
            o_autocfg_sel0_or_io0_oe <= 1'b0;
            o_autocfg_sel1_or_io1    <= 1'b0;
            o_autocfg_sel1_or_io1_oe <= 1'b0;
            o_factory_test_or_io2    <= 1'b0;
            o_factory_test_or_io2_oe <= 1'b0;
            o_general_io_state       <= 3'h0;
        end else if (i_ce && o_strap_valid) begin
            o_autocfg_sel0_or_io0    <= i_general_io_config_1[CFG1_VAL0];
            o_autocfg_sel0_or_io0_oe <= i_general_io_config_1[CFG1_OE0];
            o_autocfg_sel1_or_io1    <= i_general_io_config_1[CFG1_VAL1];
            o_autocfg_sel1_or_io1_oe <= i_general_io_config_1[CFG1_OE1];
            o_factory_test_or_io2    <= i_general_io_config_2[CFG2_VAL2];
            o_factory_test_or_io2_oe <= i_general_io_config_2[CFG2_OE2];
            o_general_io_state       <= pin_s[PIN_IO2:PIN_IO0];
        end
    end

    // ************************************************************
    // i2c slave pins
    // ************************************************************
    logic reva_tog_reg;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_i2c_scl_level    <= 1'b1;
            o_i2c_sda_level    <= 1'b1;
            o_host_data_pin_oe <= 1'b0;
            reva_tog_reg       <= 1'b0;
        end else if (i_ce) begin
            o_i2c_scl_level <= pin_s[PIN_CLK];
            o_i2c_sda_level <= pin_s[PIN_DATA];
            // in I2C mode only pulls low, the outside pullup makes the high; master mode drives both levels
            o_host_data_pin_oe <= (is_i2c & i_i2c_sda_pull_low) | is_master;
            reva_tog_reg <= i_i2c_access_busy ? ~reva_tog_reg : 1'b0;
        end
    end

    // ************************************************************
    // spi slave link
    // ************************************************************
    logic tog_seen_reg;

    rshm_spi_link u_link (
        .i_link_clk  (i_link_clk),
        .i_rst       (i_rst),
        .i_cs_n      (i_ifmode0_or_chip_select_n),
        .i_enable    (slave_en_reg),
        .i_mosi      (i_host_data_pin),
        .i_tx_byte   (i_spi_tx_byte),
        .o_miso      (link_miso),
        .o_rx_byte   (link_rx_byte),
        .o_rx_toggle (link_rx_toggle)
    );

    assign o_ifmode1_or_serial_out = link_miso;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            slave_en_reg               <= 1'b0;
            tog_seen_reg               <= 1'b0;
            o_spi_rx_byte              <= 8'h00;
            o_spi_rx_valid             <= 1'b0;
            o_ifmode1_or_serial_out_oe <= 1'b0;
        end else if (i_ce) begin
            slave_en_reg   <= is_slave;
            tog_seen_reg   <= rx_toggle_s;
            o_spi_rx_valid <= rx_toggle_s ^ tog_seen_reg;
            if (rx_toggle_s ^ tog_seen_reg) begin
                o_spi_rx_byte <= link_rx_byte;
            end
            // link output is held low outside slave mode, so the toggle only pulls low
            o_ifmode1_or_serial_out_oe <= (is_slave & ~pin_s[PIN_CS])
                | (REV_A & is_i2c & reva_tog_reg);
        end
    end

    // ************************************************************
    // spi master eeprom read
    // ************************************************************
    rshm_ee_state_t              st_reg;
    logic [7:0]                  div_reg;
    logic [EE_CNT_W-1:0]         bit_cnt_reg;
    logic [EE_CNT_W-1:0]         bit_cnt_next;
    logic [EE_HDR_BITS-1:0]      tx_sh_reg;
    logic [7:0]                  rx_sh_reg;
    logic [7:0]                  rx_sh_next;
    logic [EE_ADDR_W-1:0]        cfg_base;

    assign cfg_base     = EE_ADDR_W'(strap_reg.autocfg_select) * EE_ADDR_W'(CFG_BYTES);
    assign bit_cnt_next = bit_cnt_reg + EE_CNT_W'(1);
    assign rx_sh_next   = {rx_sh_reg[6:0], pin_s[PIN_MISO]};

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_reg                        <= ST_WAIT;
            div_reg                       <= 8'h00;
            bit_cnt_reg                   <= '0;
            tx_sh_reg                     <= '0;
            rx_sh_reg                     <= 8'h00;
            o_host_clk_pin                <= 1'b0;
            o_host_clk_pin_oe             <= 1'b0;
            o_host_data_pin               <= 1'b0;
            o_ifmode0_or_chip_select_n    <= 1'b1;
            o_ifmode0_or_chip_select_n_oe <= 1'b0;
            o_ee_byte                     <= 8'h00;
            o_ee_byte_valid               <= 1'b0;
            o_autocfg_busy                <= 1'b0;
            o_autocfg_done                <= 1'b0;
        end else if (i_ce) begin
            o_ee_byte_valid <= 1'b0;
            unique case (st_reg)
                ST_WAIT: begin
                    if (is_master) begin
                        st_reg                        <= ST_SHIFT;
                        o_autocfg_busy                <= 1'b1;
                        o_ifmode0_or_chip_select_n_oe <= 1'b1;
                        o_host_clk_pin_oe             <= 1'b1;
                        o_ifmode0_or_chip_select_n    <= 1'b0;
                        o_host_data_pin               <= EE_READ_CMD[7];
                        tx_sh_reg <= {EE_READ_CMD[6:0], cfg_base, 1'b0};
                        div_reg                       <= 8'h00;
                        bit_cnt_reg                   <= '0;
                    end else if (o_strap_valid) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    st_reg <= ST_IDLE;
                end
                ST_SHIFT: begin
                    if (div_reg == DIV_LAST) begin
                        div_reg        <= 8'h00;
                        o_host_clk_pin <= ~o_host_clk_pin;
                        if (!o_host_clk_pin) begin
                            // sampled through the synchroniser, so the divider must exceed it
                            rx_sh_reg   <= rx_sh_next;
                            bit_cnt_reg <= bit_cnt_next;
                            if (bit_cnt_next > EE_HDR && bit_cnt_next[2:0] == 3'h0) begin
                                o_ee_byte       <= rx_sh_next;
                                o_ee_byte_valid <= 1'b1;
                            end
                        end else if (bit_cnt_reg == EE_TOTAL) begin
                            st_reg                     <= ST_DONE;
                            o_ifmode0_or_chip_select_n <= 1'b1;
                            o_host_clk_pin_oe          <= 1'b0;
                            o_host_data_pin            <= 1'b0;
                            o_autocfg_busy             <= 1'b0;
                            o_autocfg_done             <= 1'b1;
                        end else begin
                            o_host_data_pin <= tx_sh_reg[EE_HDR_BITS-1];
                            tx_sh_reg       <= {tx_sh_reg[EE_HDR_BITS-2:0], 1'b0};
                        end
                    end else begin
                        div_reg <= div_reg + 8'h01;
                    end
                end
                ST_DONE: begin
                    st_reg <= ST_DONE;
                end
                default: begin
                    st_reg <= ST_WAIT;
                end
            endcase
        end
    end
endmodule

// *** rshm_pin_mux_properties.sv ***
`timescale 1ns/10ps
module rshm_pin_mux_chk
    import rshm_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_general_io_config_1,
    input wire logic [1:0]  i_general_io_config_2,
    input wire logic        i_i2c_sda_pull_low,
    input wire logic        o_autocfg_sel0_or_io0,
    input wire logic        o_autocfg_sel0_or_io0_oe,
    input wire logic        o_factory_test_or_io2,
    input wire logic        o_factory_test_or_io2_oe,
    input wire logic        o_ifmode0_or_chip_select_n,
    input wire logic        o_ifmode0_or_chip_select_n_oe,
    input wire logic        o_ifmode1_or_serial_out_oe,
    input wire logic        o_host_clk_pin_oe,
    input wire logic        o_host_data_pin,
    input wire logic        o_host_data_pin_oe,
    input wire rshm_strap_t o_strap_capture_status,
    input wire logic        o_strap_valid,
    input wire logic        o_factory_test_mode,
    input wire logic        o_autocfg_busy
);
    // ****************************************
    // pin role checks
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic [1:0] mode;
    assign mode = o_strap_capture_status.host_mode;
    property p_idle_pins;
        !o_strap_valid |-> !(o_autocfg_sel0_or_io0_oe | o_factory_test_or_io2_oe
            | o_ifmode0_or_chip_select_n_oe | o_ifmode1_or_serial_out_oe
            | o_host_clk_pin_oe | o_host_data_pin_oe);
    endproperty
    a_idle_pins: assert property (p_idle_pins)
        else $error("pin driven before strap capture");
    property p_status_held;
        $past(o_strap_valid) |-> o_strap_valid && $stable(o_strap_capture_status);
    endproperty
    a_status_held: assert property (p_status_held)
        else $error("strap status changed after capture");
    property p_test_mode;
        o_factory_test_mode == (o_strap_valid && o_strap_capture_status.factory_test);
    endproperty
    a_test_mode: assert property (p_test_mode)
        else $error("factory test mode wrong");
    property p_io0;
        $past(o_strap_valid) |-> o_autocfg_sel0_or_io0_oe == $past(i_general_io_config_1[0])
            && o_autocfg_sel0_or_io0 == $past(i_general_io_config_1[2]);
    endproperty
    a_io0: assert property (p_io0)
        else $error("io0 does not follow config");
    property p_io2;
        $past(o_strap_valid) |-> o_factory_test_or_io2_oe == $past(i_general_io_config_2[0])
            && o_factory_test_or_io2 == $past(i_general_io_config_2[1]);
    endproperty
    a_io2: assert property (p_io2)
        else $error("io2 does not follow config");
    property p_clk_out;
        o_host_clk_pin_oe |-> mode == MODE_SPI_MASTER;
    endproperty
    a_clk_out: assert property (p_clk_out)
        else $error("clock pin driven outside master mode");
    property p_miso_out;
        o_ifmode1_or_serial_out_oe |-> mode == MODE_SPI_SLAVE;
    endproperty
    a_miso_out: assert property (p_miso_out)
        else $error("serial out driven outside slave mode");
    property p_sel_low;
        o_autocfg_busy |-> o_ifmode0_or_chip_select_n_oe && !o_ifmode0_or_chip_select_n;
    endproperty
    a_sel_low: assert property (p_sel_low)
        else $error("select not low during eeprom read");
    property p_sda;
        o_strap_valid && mode == MODE_I2C |=> !o_host_data_pin
            && o_host_data_pin_oe == $past(i_i2c_sda_pull_low);
    endproperty
    a_sda: assert property (p_sda)
        else $error("data line not open drain");
endmodule
bind rshm_pin_mux rshm_pin_mux_chk chk_u (.*);

// *** rshm_pkg.sv ***
package rshm_pkg;

    // ************************************************************
    // host interface modes, taken from the two mode straps
    // ************************************************************
    localparam logic [1:0] MODE_I2C        = 2'h0;
    localparam logic [1:0] MODE_SPI_SLAVE  = 2'h1;
    localparam logic [1:0] MODE_SPI_MASTER = 2'h2;
    localparam logic [1:0] MODE_RESERVED   = 2'h3;

    // ************************************************************
    // strap capture timing
    // ************************************************************
    localparam int         SYNC_STAGES  = 2;
    localparam logic [1:0] CAPTURE_WAIT = 2'h3;

    // ************************************************************
    // synchroniser vector positions
    // ************************************************************
    localparam int PIN_IO0   = 0;
    localparam int PIN_IO1   = 1;
    localparam int PIN_IO2   = 2;
    localparam int PIN_CS    = 3;
    localparam int PIN_MISO  = 4;
    localparam int PIN_CLK   = 5;
    localparam int PIN_DATA  = 6;
    localparam int NUM_PINS  = 7;

    // ************************************************************
    // general io configuration fields
    // ************************************************************
    localparam int CFG1_OE0  = 0;
    localparam int CFG1_OE1  = 1;
    localparam int CFG1_VAL0 = 2;
    localparam int CFG1_VAL1 = 3;
    localparam int CFG2_OE2  = 0;
    localparam int CFG2_VAL2 = 1;

    // ************************************************************
    // eeprom read sequence
    // ************************************************************
    localparam logic [7:0] EE_READ_CMD  = 8'h03;
    localparam int         EE_ADDR_W    = 16;
    localparam int         EE_HDR_BITS  = 24;
    localparam int         EE_CNT_W     = 16;
    localparam int         SCLK_DIV_DEF = 4;
    localparam int         CFG_BYTES_DEF = 16;

    typedef struct packed {
        logic       factory_test;
        logic [1:0] host_mode;
        logic [1:0] autocfg_select;
    } rshm_strap_t;

    typedef enum logic [3:0] {
        ST_WAIT  = 4'h1,
        ST_IDLE  = 4'h2,
        ST_SHIFT = 4'h4,
        ST_DONE  = 4'h8
    } rshm_ee_state_t;

endpackage

// *** rshm_spi_link.sv ***
`timescale 1ns/10ps
module rshm_spi_link
    import rshm_pkg::*;
(
    input  wire logic       i_link_clk,
    input  wire logic       i_rst,
    input  wire logic       i_cs_n,
    input  wire logic       i_enable,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_tx_byte,
    output logic            o_miso,
    output logic [7:0]      o_rx_byte,
    output logic            o_rx_toggle
);
    logic       frame_rst;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic [7:0] rx_sh_next;

    // frame ends by its own select; link clock may stop outside frames
    assign frame_rst  = i_rst | i_cs_n | ~i_enable;
    assign rx_sh_next = {rx_sh_reg[6:0], i_mosi};
    assign o_miso     = tx_sh_reg[7];

    always_ff @(posedge i_link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg   <= 8'h00;
            tx_sh_reg   <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg   <= rx_sh_next;
            if (bit_cnt_reg == 3'h7) begin
                tx_sh_reg <= i_tx_byte;
            end else begin
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // byte word stays put until the next byte, toggle tells the core
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_byte   <= 8'h00;
            o_rx_toggle <= 1'b0;
        end else if (!frame_rst && bit_cnt_reg == 3'h7) begin
            o_rx_byte   <= rx_sh_next;
            o_rx_toggle <= ~o_rx_toggle;
        end
    end
endmodule

// *** rshm_sync.sv ***
`timescale 1ns/10ps
module rshm_sync
    import rshm_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
    import rshm_pkg::*;
    localparam int CFG_B = 2;
    logic        i_mclk = 1'b0, i_rst = 1'b1, pull = 1'b0, use_ee = 1'b0;
    logic [6:0]  drv = 7'h40;
    logic [3:0]  cfg1 = 4'h0;
    logic [1:0]  cfg2 = 2'h0;
    logic [7:0]  tx = 8'h00, seed = 8'h5E, rx_b, ee_b;
    wire  [6:0]  po, poe, pin;
    logic        rx_v, ee_v, ee_miso, ab, ad, scl_l, sda_l, sv, ftm;
    logic [2:0]  gst;
    logic [23:0] hdr;
    rshm_strap_t st;
    logic [7:0]  rxq[$], eeq[$];
    int          n_errors = 0, cmp_count = 0;
    // ****************************************
    // wires: undriven pins take the bench level
    // ****************************************
    always #5 i_mclk = ~i_mclk;
    assign pin[3:0] = (poe[3:0] & po[3:0]) | (~poe[3:0] & drv[3:0]);
    assign pin[4] = poe[4] ? po[4] : (use_ee ? ee_miso : drv[4]);
    assign pin[6:5] = (poe[6:5] & po[6:5]) | (~poe[6:5] & drv[6:5]);
    rshm_pin_mux #(.SCLK_DIV(4), .CFG_BYTES(CFG_B), .REV_A(1'b0)) dut_u (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_link_clk(pin[5]),
        .i_autocfg_sel0_or_io0(pin[0]), .o_autocfg_sel0_or_io0(po[0]),
        .o_autocfg_sel0_or_io0_oe(poe[0]), .i_autocfg_sel1_or_io1(pin[1]),
        .o_autocfg_sel1_or_io1(po[1]), .o_autocfg_sel1_or_io1_oe(poe[1]),
        .i_factory_test_or_io2(pin[2]), .o_factory_test_or_io2(po[2]),
        .o_factory_test_or_io2_oe(poe[2]), .i_ifmode0_or_chip_select_n(pin[3]),
        .o_ifmode0_or_chip_select_n(po[3]), .o_ifmode0_or_chip_select_n_oe(poe[3]),
        .i_ifmode1_or_serial_out(pin[4]), .o_ifmode1_or_serial_out(po[4]),
        .o_ifmode1_or_serial_out_oe(poe[4]), .i_host_clk_pin(pin[5]),
        .o_host_clk_pin(po[5]), .o_host_clk_pin_oe(poe[5]), .i_host_data_pin(pin[6]),
        .o_host_data_pin(po[6]), .o_host_data_pin_oe(poe[6]), .i_general_io_config_1(cfg1),
        .i_general_io_config_2(cfg2), .o_general_io_state(gst), .o_strap_capture_status(st),
        .o_strap_valid(sv), .o_factory_test_mode(ftm), .i_i2c_sda_pull_low(pull),
        .i_i2c_access_busy(seed[7]), .o_i2c_scl_level(scl_l), .o_i2c_sda_level(sda_l),
        .i_spi_tx_byte(tx), .o_spi_rx_byte(rx_b), .o_spi_rx_valid(rx_v), .o_ee_byte(ee_b),
        .o_ee_byte_valid(ee_v), .o_autocfg_busy(ab), .o_autocfg_done(ad));
    rshm_ee_model ee_u (.i_cs_n(pin[3]), .i_sclk(pin[5]), .i_mosi(pin[6]), .o_miso(ee_miso),
        .o_hdr(hdr));
    always @(posedge i_mclk) begin
        if (rx_v === 1'b1) rxq.push_back(rx_b);
        if (ee_v === 1'b1) eeq.push_back(ee_b);
    end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] ee_exp(input logic [1:0] sel, input int k);
        return 8'(int'(sel) * CFG_B + k) ^ 8'h5A;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input logic ok, input string m);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // link clock runs only inside a frame, off the core clock grid
    task automatic spi_frame(input logic [15:0] w, output logic [7:0] so);
        drv[3] = 1'b0;
        step(6);
        #3.3;
        for (int i = 0; i < 16; i++) begin
            drv[6] = w[15-i];
            #40 drv[5] = 1'b1;
            #40 drv[5] = 1'b0;
            if (i >= 7 && i < 15) so = {so[6:0], pin[4]};
        end
        step(6);
        drv[3] = 1'b1;
    endtask
    task automatic run(input logic [1:0] m);
        logic [1:0] sel;
        logic       tst;
        logic [7:0] so;
        logic [2:0] oe;
        int         w;
        seed = nxt(seed);
        {tst, sel} = seed[2:0];
        i_rst = 1'b1;
        use_ee = 1'b0;
        drv = {2'b10, m, tst, sel};
        step(1);
        chk(sv === 1'b0 && st === '0 && poe === '0, "reset state");
        step(5);
        i_rst = 1'b0;
        w = 0;
        while (sv !== 1'b1 && w < 20) begin
            step(1);
            w++;
        end
        chk(st === {tst, m, sel} && ftm === tst, "strap capture");
        drv[2:0] = ~drv[2:0];
        seed = nxt(seed);
        {cfg2, cfg1} = seed[5:0];
        oe = {cfg2[0], cfg1[1:0]};
        step(6);
        chk(st === {tst, m, sel}, "status held");
        chk(poe[2:0] === oe, "io enables");
        chk(pin[2:0] === ((oe & {cfg2[1], cfg1[3:2]}) | (~oe & drv[2:0])), "io out");
        chk(gst === pin[2:0], "io state");
        case (m)
            MODE_I2C: begin
                pull = 1'b1;
                drv[5] = 1'b0;
                step(4);
                chk(poe[5] === 1'b0 && scl_l === 1'b0, "bus clock in");
                chk(pin[6] === 1'b0 && sda_l === 1'b0, "data pulled");
                pull = 1'b0;
            end
            MODE_SPI_SLAVE: begin
                tx = nxt(seed);
                rxq.delete();
                spi_frame({8'hA5, ~tx}, so);
                step(8);
                chk(rxq.size() == 2 && rxq[0] === 8'hA5 && rxq[1] === ~tx, "slave rx");
                chk(so === tx, "slave read data");
            end
            MODE_SPI_MASTER: begin
                use_ee = 1'b1;
                eeq.delete();
                w = 0;
                while (ad !== 1'b1 && w < 1000) begin
                    step(1);
                    w++;
                end
                chk(hdr === {EE_READ_CMD, 16'(int'(sel) * CFG_B)}, "read header");
                chk(eeq.size() == CFG_B && eeq[0] === ee_exp(sel, 0)
                    && eeq[1] === ee_exp(sel, 1), "eeprom bytes");
                chk(ab === 1'b0 && pin[3] === 1'b1, "select released");
            end
            default: begin
                step(10);
                chk(poe[6:3] === 4'h0, "reserved idle");
            end
        endcase
    endtask
    initial begin
        for (int r = 0; r < 8; r++) begin
            run(2'(r));
        end
        end_sim;
    end
    initial begin
        #300000;
        n_errors++;
        end_sim;
    end
endmodule
